// ===== testbench/gpiom_monitor.sv
// Checker on the top ports of the GPIO block with pin multiplexing.
// Assumes one clock domain and bind onto every gpiom_top instance.
`timescale 1ns/1ps

module gpiom_monitor #(
	parameter WIDTH = 8
) (
	// Clock and reset
	input wire sys_clk,
	input wire rst,
	// Configuration and output writes, first SPI clock
	input wire [3:0] port_cfg_we,
	input wire [4*WIDTH-1:0] port_output_enable,
	input wire [4*WIDTH-1:0] port_pullup_enable,
	input wire [4*WIDTH-1:0] input_path_enable,
	input wire [4*WIDTH-1:0] port_open_drain_enable,
	input wire [2*WIDTH-1:0] port1_function_select,
	input wire [2*WIDTH-1:0] port2_function_select,
	input wire [3:0] port_out_we,
	input wire [2:0] port_out_op,
	input wire [WIDTH-1:0] port_out_wdata,
	input wire spi_first_sclk_out,
	// Observed outputs
	input wire [4*WIDTH-1:0] pad_out,
	input wire [4*WIDTH-1:0] pad_oe,
	input wire [4*WIDTH-1:0] pad_pullup,
	input wire [4*WIDTH-1:0] port_input_value,
	input wire [4*WIDTH-1:0] port_output_value,
	input wire [4*WIDTH-1:0] pin_irq,
	input wire [8*WIDTH-1:0] function_select_value
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	// ==========================================================
	// Output register actions on port 0
	property p_set;
		port_out_we[0] && port_out_op == 3'h1 |=>
			port_output_value[7:0] == ($past(port_output_value[7:0]) | $past(port_out_wdata));
	endproperty
	a_set: assert property (p_set) else $error("set write result wrong");
	property p_clr;
		port_out_we[0] && port_out_op == 3'h2 |=>
			port_output_value[7:0] == ($past(port_output_value[7:0]) & ~$past(port_out_wdata));
	endproperty
	a_clr: assert property (p_clr) else $error("clear write result wrong");
	property p_tgl;
		port_out_we[0] && port_out_op == 3'h3 |=>
			port_output_value[7:0] == ($past(port_output_value[7:0]) ^ $past(port_out_wdata));
	endproperty
	a_tgl: assert property (p_tgl) else $error("toggle write result wrong");

	// ==========================================================
	// Configuration and pad control
	property p_fsel;
		port_cfg_we[2] |=> function_select_value[47:32] == $past(port2_function_select);
	endproperty
	a_fsel: assert property (p_fsel) else $error("function select not loaded");
	property p_pull;
		port_cfg_we[1] && port1_function_select == 16'h0000 ##1 !port_cfg_we[1] |=>
			pad_pullup[15:8] == $past(port_pullup_enable[15:8] & ~port_output_enable[15:8]
			& ~port_open_drain_enable[15:8], 2);
	endproperty
	a_pull: assert property (p_pull) else $error("pull-up control wrong");
	property p_gate;
		port_cfg_we[2] ##1 (!port_cfg_we[2])[*4] |->
			((port_input_value[23:16] | pin_irq[23:16]) & ~$past(input_path_enable[23:16], 4)) == 8'h00
			&& (pin_irq[23:16] & $past(port_open_drain_enable[23:16], 4)) == 8'h00;
	endproperty
	a_gate: assert property (p_gate) else $error("input path not gated");
	property p_rst;
		$fell(rst) |-> function_select_value == 64'h0000_0010_0000_0000
			&& pad_pullup == 32'h0 && pad_oe == 32'h0 && port_output_value == 32'h0;
	endproperty
	a_rst: assert property (p_rst) else $error("reset state wrong");
	property p_route;
		function_select_value[1:0] == 2'h1 && $past(function_select_value[1:0]) == 2'h1
			|-> pad_out[0] == $past(spi_first_sclk_out);
	endproperty
	a_route: assert property (p_route) else $error("clock route wrong");
	property p_drive;
		function_select_value[31:16] == 16'h0000 && $past(function_select_value[31:16]) == 16'h0000
			|-> (pad_out[15:8] & pad_oe[15:8]) == ($past(port_output_value[15:8]) & pad_oe[15:8]);
	endproperty
	a_drive: assert property (p_drive) else $error("driven pin value wrong");
endmodule // gpiom_monitor

bind gpiom_top gpiom_monitor #(.WIDTH(WIDTH)) i_mon (.*);

// ===== testbench/gpiom_pads.sv
// Model of the pins and whatever drives them from outside the chip.
// Assumes the bench picks which pins it drives; released pins wander.
`timescale 1ns/1ps

module gpiom_pads (
	// Clock
	input wire sys_clk,
	// Device pad controls
	input wire [31:0] pad_out,
	input wire [31:0] pad_oe,
	input wire [31:0] pad_pullup,
	// Outside drivers
	input wire [31:0] ext_en,
	input wire [31:0] ext_val,
	// Pin levels seen by the device
	output wire [31:0] pad_in
);
	reg [31:0] float_q = 32'h5555_5555;

	// A floating pin shows a changing level, never a stale one
	always @(posedge sys_clk) begin
		float_q <= ~float_q;
	end

	// Device driver, outside driver, pull-up, else floating
	assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
		| (~pad_oe & ~ext_en & (pad_pullup | float_q));
endmodule // gpiom_pads

// ===== testbench/tb_top.sv
// Self-checking bench for the GPIO block with pin multiplexing.
// Assumes the design, the pad model and the bound checker are compiled first.
`timescale 1ns/1ps

module tb_top;
	reg sys_clk = 1'b0;
	reg rst = 1'b1;
	reg [3:0] port_cfg_we = 4'h0, port_out_we = 4'h0;
	reg [2:0] port_out_op = 3'h0;
	reg [7:0] port_out_wdata = 8'h00;
	reg [31:0] port_output_enable = 32'h0, port_pullup_enable = 32'h0;
	reg [31:0] input_path_enable = 32'hffff_ffff, port_open_drain_enable = 32'h0;
	reg [15:0] port0_function_select = 16'h0, port1_function_select = 16'h0;
	reg [15:0] port2_function_select = 16'h0, port3_function_select = 16'h0;
	reg [31:0] ext_en = 32'h0, ext_val = 32'h0;
	reg [59:0] pv = 60'h5a9_6c3e_17b2_8d41;
	wire [31:0] pad_in, pad_out, pad_oe, pad_pullup, port_input_value, port_output_value, pin_irq;
	wire [63:0] function_select_value;
	wire [3:0] spi_first_in, i2c_in, spi_second_in, i2c_scl_sda_drive_low;
	wire [15:0] logic_array_input;
	wire uart_rx, external_clock_input, logic_array_clock_a, logic_array_clock_b;
	wire logic_array_clock_c, pwm_trip_input, pwm_sync_input, adc_convert_start;
	wire spi_first_sclk_out, spi_first_sclk_oe, spi_first_mosi_out, spi_first_cs_out;
	wire spi_first_cs_oe, spi_first_miso_out, spi_first_miso_oe, spi_first_mosi_oe;
	wire spi_second_sclk_out, spi_second_sclk_oe, spi_second_mosi_out, spi_second_mosi_oe;
	wire spi_second_cs_out, spi_second_cs_oe, spi_second_miso_out, spi_second_miso_oe;
	wire uart_tx, clock_out_src;
	wire [7:0] pwm_out;
	wire [29:0] logic_array_output;
	integer bad_count = 0, tests_run = 0, i, j;
	reg [15:0] seen;
	reg [7:0] d, e;
	reg [2:0] op;
	reg [3:0] v;

	gpiom_top #(.WIDTH(8)) i_dut (.*);
	gpiom_pads i_pads (.*);

	// ==========================================================
	// Clock and peripheral stimulus
	initial begin
		forever #2.5 sys_clk = ~sys_clk;
	end
	assign {spi_first_sclk_out, spi_first_sclk_oe, spi_first_mosi_out, spi_first_cs_out,
		spi_first_cs_oe, spi_first_miso_out, spi_first_miso_oe, spi_first_mosi_oe,
		spi_second_sclk_out, spi_second_sclk_oe, spi_second_mosi_out, spi_second_mosi_oe,
		spi_second_cs_out, spi_second_cs_oe, spi_second_miso_out, spi_second_miso_oe,
		uart_tx, clock_out_src, i2c_scl_sda_drive_low, pwm_out, logic_array_output} = pv;
	always @(posedge sys_clk) begin
		pv <= {pv[58:0], ~pv[59]};
	end

	// ==========================================================
	// Access tasks and comparison
	task chk(input logic [63:0] s, input logic [63:0] x);
		tests_run = tests_run + 1;
		if (s !== x) begin
			bad_count = bad_count + 1;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask
	task cfg(input integer p, input [7:0] oe, pu, ie, od, input [15:0] fs);
		@(posedge sys_clk);
		port_output_enable[p*8+:8] <= oe;
		port_pullup_enable[p*8+:8] <= pu;
		input_path_enable[p*8+:8] <= ie;
		port_open_drain_enable[p*8+:8] <= od;
		{port0_function_select, port1_function_select} <= {2{fs}};
		{port2_function_select, port3_function_select} <= {2{fs}};
		port_cfg_we <= 4'h1 << p;
		@(posedge sys_clk);
		port_cfg_we <= 4'h0;
		#1;
	endtask
	task wr(input integer p, input [2:0] o, input [7:0] w);
		@(posedge sys_clk);
		port_out_op <= o;
		port_out_wdata <= w;
		port_out_we <= 4'h1 << p;
		@(posedge sys_clk);
		port_out_we <= 4'h0;
		#1;
	endtask
	task conclude;
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ==========================================================
	// Test sequence
	initial begin
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		#1;
		chk(function_select_value, 64'h0000_0010_0000_0000);
		chk({pad_pullup, pad_oe}, 64'h0);
		// Write, set, clear, toggle and an ignored action on port 0
		cfg(0, 8'hff, 8'hff, 8'hff, 8'h00, 16'h0000);
		e = 8'h00;
		d = 8'h3c;
		for (i = 0; i < 5; i = i + 1) begin
			d = {d[6:0], d[7]} ^ 8'h5a;
			op = (i == 4) ? 3'h5 : i[2:0];
			wr(0, op, d);
			case (op)
				3'h0: e = d;
				3'h1: e = e | d;
				3'h2: e = e & ~d;
				3'h3: e = e ^ d;
				default: e = e;
			endcase
			chk(port_output_value, {24'h0, e});
		end
		@(posedge sys_clk);
		#1;
		chk({pad_oe[7:0], pad_out[7:0], pad_pullup[7:0]}, {8'hff, e, 8'h00});
		// Pull-ups and open drain on port 1
		cfg(1, 8'h0f, 8'hff, 8'hff, 8'h33, 16'h0000);
		wr(1, 3'h1, 8'hff);
		@(posedge sys_clk);
		#1;
		chk({pad_pullup[15:8], pad_oe[15:8]}, 16'hc00c);
		wr(1, 3'h2, 8'h01);
		@(posedge sys_clk);
		#1;
		chk(pad_oe[15:8], 8'h0d);
		// Input path on port 2, one pin floating in open drain
		@(posedge sys_clk);
		ext_en[23:16] <= 8'hfc;
		ext_val[23:16] <= 8'ha5;
		wr(2, 3'h1, 8'h01);
		cfg(2, 8'h03, 8'h00, 8'h7f, 8'h41, 16'h00d0);
		repeat (6) @(posedge sys_clk);
		#1;
		chk(port_input_value[23:16], 8'h24);
		chk(pin_irq[23:16] & 8'h81, 8'h00);
		@(posedge sys_clk);
		ext_val[23:16] <= 8'h5a;
		repeat (6) @(posedge sys_clk);
		#1;
		chk(port_input_value[23:16], 8'h58);
		// Pin 6 is open drain but not an output: input seen, no request
		chk(pin_irq[23:16], 8'h18);
		// Alternate functions on all four ports
		for (i = 0; i < 4; i = i + 1) begin
			cfg(i, 8'h00, 8'hff, 8'hff, 8'h00, 16'h0b11);
		end
		for (i = 0; i < 4; i = i + 1) begin
			@(posedge sys_clk);
			v = {pwm_out[7], logic_array_output[26], pwm_out[0], spi_first_sclk_out};
			#1;
			chk({pad_out[21], pad_out[28], pad_out[10], pad_out[0]}, v);
		end
		@(posedge sys_clk);
		ext_en <= 32'h0001_0100;
		for (i = 0; i < 2; i = i + 1) begin
			@(posedge sys_clk);
			ext_val <= {32{i[0]}};
			repeat (6) @(posedge sys_clk);
			#1;
			chk({uart_rx, pwm_trip_input}, {2{i[0]}});
		end
		// Codes 11, 10 and 01 on all ports: routed inputs and driven pins
		for (i = 0; i < 3; i = i + 1) begin
			for (j = 0; j < 4; j = j + 1) begin
				cfg(j, 8'h00, 8'h00, 8'hff, 8'h00, (i == 0) ? 16'hffff :
					(i == 1) ? 16'haaaa : 16'h5555);
			end
			@(posedge sys_clk);
			ext_en <= (i == 0) ? 32'h0f0f_0f0f : (i == 1) ? 32'h0001_0308 : 32'h0013_0100;
			ext_val <= (i == 0) ? 32'h0a05_0c03 : (i == 1) ? 32'h0001_0208 : 32'h0012_0000;
			v[1:0] = (i == 0) ? {logic_array_output[10], logic_array_output[2]} :
				(i == 1) ? {spi_second_sclk_out, e[4]} : {pwm_out[2], 1'b0};
			#1;
			chk({pad_out[12], pad_out[4]}, v[1:0]);
			repeat (6) @(posedge sys_clk);
			#1;
			seen = (i == 0) ? logic_array_input : (i == 1) ? {12'h000, logic_array_clock_a,
				external_clock_input, logic_array_clock_b, logic_array_clock_c} :
				{12'h000, uart_rx, pwm_trip_input, pwm_sync_input, adc_convert_start};
			chk(seen, (i == 0) ? 16'ha5c3 : (i == 1) ? 16'h000b : 16'h0003);
		end
		conclude;
	end

	// Cut a hung run short
	initial begin
		#100000;
		bad_count = bad_count + 1;
		conclude;
	end
endmodule // tb_top

// ===== verilog/gpiom_map.vh
// Constants for the four-port GPIO block with pin multiplexing.
// Assumes inclusion by bare name from design files of the block.
`ifndef GPIOM_MAP_VH
`define GPIOM_MAP_VH

// ============================================================
// Function select codes
`define GPIOM_FS_IO 2'h0
`define GPIOM_FS_ALT1 2'h1
`define GPIOM_FS_ALT2 2'h2
`define GPIOM_FS_ALT3 2'h3

// ============================================================
// Reset values
`define GPIOM_RST_OE 8'h00
`define GPIOM_RST_PU 8'h00
`define GPIOM_RST_IE 8'hff
`define GPIOM_RST_OUT 8'h00
`define GPIOM_RST_OD 8'h00
`define GPIOM_RST_FS 16'h0000
`define GPIOM_RST_FS_P2 16'h0010

// ============================================================
// Action codes of the output write port
`define GPIOM_WR_OUT 3'h0
`define GPIOM_WR_SET 3'h1
`define GPIOM_WR_CLR 3'h2
`define GPIOM_WR_TGL 3'h3

`endif

// ===== verilog/gpiom_pin.v
// One port of eight pins: config registers, output register, pad control.
// Assumes pad inputs are asynchronous and the alternate-function map is given by the parent.
`timescale 1ns/1ps
`include "gpiom_map.vh"

module gpiom_pin #(
	parameter WIDTH = 8,
	parameter [15:0] FS_RESET = `GPIOM_RST_FS
) (
	// Clock and reset
	input wire sys_clk,
	input wire rst,
	// Configuration writes
	input wire cfg_we,
	input wire [WIDTH-1:0] oe_in,
	input wire [WIDTH-1:0] pu_in,
	input wire [WIDTH-1:0] ie_in,
	input wire [WIDTH-1:0] od_in,
	input wire [2*WIDTH-1:0] fs_in,
	// Output value write with action select
	input wire out_we,
	input wire [2:0] out_op,
	input wire [WIDTH-1:0] out_wdata,
	// Alternate function drive, per pin
	input wire [WIDTH-1:0] alt_sel,
	input wire [WIDTH-1:0] alt_out,
	input wire [WIDTH-1:0] alt_oe,
	// Pad side
	input wire [WIDTH-1:0] pad_in,
	output reg [WIDTH-1:0] pad_out_q,
	output reg [WIDTH-1:0] pad_oe_q,
	output reg [WIDTH-1:0] pad_pu_q,
	// Status
	output reg [WIDTH-1:0] in_value_q,
	output reg [WIDTH-1:0] irq_q,
	output reg [WIDTH-1:0] out_value_q,
	output reg [2*WIDTH-1:0] fs_q
);

reg [WIDTH-1:0] oe_q;
reg [WIDTH-1:0] pu_q;
reg [WIDTH-1:0] ie_q;
reg [WIDTH-1:0] od_q;
reg [WIDTH-1:0] sync1_q;
reg [WIDTH-1:0] sync2_q;
reg [WIDTH-1:0] out_d;
wire [WIDTH-1:0] in_gate;

// ============================================================
// Configuration registers
always @(posedge sys_clk or posedge rst) begin
	if (rst) begin
		oe_q <= `GPIOM_RST_OE;
		pu_q <= `GPIOM_RST_PU;
		ie_q <= `GPIOM_RST_IE;
		od_q <= `GPIOM_RST_OD;
		fs_q <= FS_RESET;
	end else if (cfg_we) begin
		oe_q <= oe_in;
		pu_q <= pu_in;
		ie_q <= ie_in;
		od_q <= od_in;
		fs_q <= fs_in;
	end
end

// ============================================================
// Output value with set, clear and toggle actions
always @* begin
	out_d = out_value_q;
	if (out_we) begin
		case (out_op)
			`GPIOM_WR_OUT: out_d = out_wdata;
			`GPIOM_WR_SET: out_d = out_value_q | out_wdata;
			`GPIOM_WR_CLR: out_d = out_value_q & ~out_wdata;
			`GPIOM_WR_TGL: out_d = out_value_q ^ out_wdata;
			default: out_d = out_value_q;
		endcase
	end
end

always @(posedge sys_clk or posedge rst) begin
	if (rst)
		out_value_q <= `GPIOM_RST_OUT;
	else
		out_value_q <= out_d;
end

// ============================================================
// Input path is off when an open-drain pin is an output
assign in_gate = ie_q & ~(oe_q & od_q);

// Two-stage synchroniser, then gated capture
always @(posedge sys_clk or posedge rst) begin
	if (rst) begin
		sync1_q <= {WIDTH{1'b0}};
		sync2_q <= {WIDTH{1'b0}};
		in_value_q <= {WIDTH{1'b0}};
		irq_q <= {WIDTH{1'b0}};
	end else begin
		sync1_q <= pad_in;
		sync2_q <= sync1_q;
		in_value_q <= sync2_q & in_gate;
		irq_q <= sync2_q & in_gate & ~od_q;
	end
end

// ============================================================
// Pad drive, per pin
genvar i;
generate
	for (i = 0; i < WIDTH; i = i + 1) begin : g_pad
		always @(posedge sys_clk or posedge rst) begin
			if (rst) begin
				pad_out_q[i] <= 1'b0;
				pad_oe_q[i] <= 1'b0;
				pad_pu_q[i] <= 1'b0;
			end else if (alt_sel[i]) begin
				pad_out_q[i] <= alt_out[i];
				pad_oe_q[i] <= alt_oe[i];
				pad_pu_q[i] <= 1'b0;
			end else begin
				pad_out_q[i] <= out_value_q[i];
				// Open drain drives low only; a one leaves the pin free
				pad_oe_q[i] <= oe_q[i] & ~(od_q[i] & out_value_q[i]);
				// Pull-up only for a plain input pin
				pad_pu_q[i] <= pu_q[i] & ~oe_q[i] & ~od_q[i];
			end
		end
	end
endgenerate

endmodule // gpiom_pin

// ===== verilog/gpiom_top.v
// Four GPIO ports with per-pin function select routing to peripherals.
// Assumes pads resolve the pin from out/oe/pullup; peripherals on sys_clk.
`timescale 1ns/1ps
`include "gpiom_map.vh"

module gpiom_top #(
	parameter WIDTH = 8
) (
	// Clock and reset
	input wire sys_clk,
	input wire rst,
	// Configuration write, one strobe per port
	input wire [3:0] port_cfg_we,
	input wire [4*WIDTH-1:0] port_output_enable,
	input wire [4*WIDTH-1:0] port_pullup_enable,
	input wire [4*WIDTH-1:0] input_path_enable,
	input wire [4*WIDTH-1:0] port_open_drain_enable,
	input wire [2*WIDTH-1:0] port0_function_select,
	input wire [2*WIDTH-1:0] port1_function_select,
	input wire [2*WIDTH-1:0] port2_function_select,
	input wire [2*WIDTH-1:0] port3_function_select,
	// Output value write: per-port strobe, action, data
	input wire [3:0] port_out_we,
	input wire [2:0] port_out_op,
	input wire [WIDTH-1:0] port_out_wdata,
	// Pads
	input wire [4*WIDTH-1:0] pad_in,
	output wire [4*WIDTH-1:0] pad_out,
	output wire [4*WIDTH-1:0] pad_oe,
	output wire [4*WIDTH-1:0] pad_pullup,
	// Status read-back
	output wire [4*WIDTH-1:0] port_input_value,
	output wire [4*WIDTH-1:0] port_output_value,
	output wire [4*WIDTH-1:0] pin_irq,
	output wire [8*WIDTH-1:0] function_select_value,
	// Peripheral outputs towards pins
	input wire spi_first_sclk_out,
	input wire spi_first_sclk_oe,
	input wire spi_first_mosi_out,
	input wire spi_first_cs_out,
	input wire spi_first_cs_oe,
	input wire spi_first_miso_out,
	input wire spi_first_miso_oe,
	input wire spi_first_mosi_oe,
	input wire [3:0] i2c_scl_sda_drive_low,
	input wire uart_tx,
	input wire [7:0] pwm_out,
	input wire spi_second_sclk_out,
	input wire spi_second_sclk_oe,
	input wire spi_second_mosi_out,
	input wire spi_second_mosi_oe,
	input wire spi_second_cs_out,
	input wire spi_second_cs_oe,
	input wire spi_second_miso_out,
	input wire spi_second_miso_oe,
	input wire clock_out_src,
	input wire [29:0] logic_array_output,
	// Peripheral inputs from pins (synchronised, registered)
	output reg [3:0] spi_first_in,
	output reg [3:0] i2c_in,
	output reg uart_rx,
	output reg external_clock_input,
	output reg logic_array_clock_a,
	output reg logic_array_clock_b,
	output reg logic_array_clock_c,
	output reg [3:0] spi_second_in,
	output reg pwm_trip_input,
	output reg pwm_sync_input,
	output reg adc_convert_start,
	output reg [15:0] logic_array_input
);

// ============================================================
// Per-port alternate routing nets
wire [4*WIDTH-1:0] alt_sel;
wire [4*WIDTH-1:0] alt_out;
wire [4*WIDTH-1:0] alt_oe;
wire [8*WIDTH-1:0] fs;
wire [4*WIDTH-1:0] pad_out_i;
wire [4*WIDTH-1:0] pad_oe_i;
wire [4*WIDTH-1:0] pad_pu_i;
wire [4*WIDTH-1:0] in_val;
wire [4*WIDTH-1:0] irq_i;
wire [4*WIDTH-1:0] out_val;
reg [4*WIDTH-1:0] psync1_q;
reg [4*WIDTH-1:0] psync2_q;
wire [2*WIDTH-1:0] fs_wr [0:3];

assign fs_wr[0] = port0_function_select;
assign fs_wr[1] = port1_function_select;
assign fs_wr[2] = port2_function_select;
assign fs_wr[3] = port3_function_select;

// ============================================================
// Four ports
genvar p;
generate
	for (p = 0; p < 4; p = p + 1) begin : g_port
		gpiom_pin #(
			.WIDTH(WIDTH),
			.FS_RESET((p == 2) ? `GPIOM_RST_FS_P2 : `GPIOM_RST_FS)
		) u_port (
			.sys_clk(sys_clk),
			.rst(rst),
			.cfg_we(port_cfg_we[p]),
			.oe_in(port_output_enable[p*WIDTH +: WIDTH]),
			.pu_in(port_pullup_enable[p*WIDTH +: WIDTH]),
			.ie_in(input_path_enable[p*WIDTH +: WIDTH]),
			.od_in(port_open_drain_enable[p*WIDTH +: WIDTH]),
			.fs_in(fs_wr[p]),
			.out_we(port_out_we[p]),
			.out_op(port_out_op),
			.out_wdata(port_out_wdata),
			.alt_sel(alt_sel[p*WIDTH +: WIDTH]),
			.alt_out(alt_out[p*WIDTH +: WIDTH]),
			.alt_oe(alt_oe[p*WIDTH +: WIDTH]),
			.pad_in(pad_in[p*WIDTH +: WIDTH]),
			.pad_out_q(pad_out_i[p*WIDTH +: WIDTH]),
			.pad_oe_q(pad_oe_i[p*WIDTH +: WIDTH]),
			.pad_pu_q(pad_pu_i[p*WIDTH +: WIDTH]),
			.in_value_q(in_val[p*WIDTH +: WIDTH]),
			.irq_q(irq_i[p*WIDTH +: WIDTH]),
			.out_value_q(out_val[p*WIDTH +: WIDTH]),
			.fs_q(fs[p*2*WIDTH +: 2*WIDTH])
		);
	end
endgenerate

// Port outputs come from flip-flops inside the port module
assign pad_out = pad_out_i;
assign pad_oe = pad_oe_i;
assign pad_pullup = pad_pu_i;
assign port_input_value = in_val;
assign port_output_value = out_val;
assign pin_irq = irq_i;
assign function_select_value = fs;

// Field of pin n of port p
`define GPIOM_F(p, n) fs[(p)*2*WIDTH + 2*(n) +: 2]

// ============================================================
// Alternate output routing; unassigned codes fall back to plain I/O
function [2:0] gpiom_alt;
	input [1:0] code;
	input sel1;
	input sel2;
	input sel3;
	input [1:0] d1;
	input [1:0] d2;
	input [1:0] d3;
	begin
		gpiom_alt = 3'h0;
		case (code)
			`GPIOM_FS_ALT1: gpiom_alt = {sel1, d1};
			`GPIOM_FS_ALT2: gpiom_alt = {sel2, d2};
			`GPIOM_FS_ALT3: gpiom_alt = {sel3, d3};
			default: gpiom_alt = 3'h0;
		endcase
	end
endfunction

// Each entry: {select, out, oe}; inputs-only functions select with oe low
wire [3*4*WIDTH-1:0] alt_bus;
// Port 0
assign alt_bus[3*0 +: 3] = gpiom_alt(`GPIOM_F(0, 0), 1'b1, 1'b0, 1'b1,
	{spi_first_sclk_out, spi_first_sclk_oe}, 2'h0, 2'h0);
assign alt_bus[3*1 +: 3] = gpiom_alt(`GPIOM_F(0, 1), 1'b1, 1'b0, 1'b1,
	{spi_first_miso_out, spi_first_miso_oe}, 2'h0, 2'h0);
assign alt_bus[3*2 +: 3] = gpiom_alt(`GPIOM_F(0, 2), 1'b1, 1'b0, 1'b1,
	{spi_first_mosi_out, spi_first_mosi_oe}, 2'h0, 2'h0);
assign alt_bus[3*3 +: 3] = gpiom_alt(`GPIOM_F(0, 3), 1'b1, 1'b1, 1'b1,
	{spi_first_cs_out, spi_first_cs_oe}, 2'h0, 2'h0);
genvar k;
generate
	for (k = 0; k < 4; k = k + 1) begin : g_p0_hi
		// I2C is open drain: drive low only; logic-array output drives
		assign alt_bus[3*(4+k) +: 3] = gpiom_alt(`GPIOM_F(0, 4+k), 1'b1, 1'b0, 1'b1,
			{1'b0, i2c_scl_sda_drive_low[k]}, 2'h0,
			{logic_array_output[2+k], 1'b1});
	end
	// Port 1 pins 2..7 carry PWM 0..5 on code 01
	for (k = 2; k < 8; k = k + 1) begin : g_p1_pwm
		// Code 11: pins 2..3 are logic-array inputs, pins 4..7 logic-array outputs 10..13
		assign alt_bus[3*(WIDTH+k) +: 3] = gpiom_alt(`GPIOM_F(1, k), 1'b1, (k >= 4), 1'b1,
			{pwm_out[k-2], 1'b1},
			(k == 4) ? {spi_second_sclk_out, spi_second_sclk_oe} :
			(k == 5) ? {spi_second_miso_out, spi_second_miso_oe} :
			(k == 6) ? {spi_second_mosi_out, spi_second_mosi_oe} :
			{spi_second_cs_out, spi_second_cs_oe},
			(k >= 4) ? {logic_array_output[6+k], 1'b1} : 2'h0);
	end
	// Port 2 pins 6, 7 and port 3 have only logic-array on code 11; port 2 pin 3 stays plain I/O
	for (k = 0; k < 8; k = k + 1) begin : g_p3
		assign alt_bus[3*(3*WIDTH+k) +: 3] = gpiom_alt(`GPIOM_F(3, k), 1'b0, 1'b0, 1'b1,
			2'h0, 2'h0, (k >= 4) ? {logic_array_output[22+k], 1'b1} : 2'h0);
	end
endgenerate
assign alt_bus[3*(WIDTH+0) +: 3] = gpiom_alt(`GPIOM_F(1, 0), 1'b1, 1'b1, 1'b1,
	2'h0, 2'h0, 2'h0);
assign alt_bus[3*(WIDTH+1) +: 3] = gpiom_alt(`GPIOM_F(1, 1), 1'b1, 1'b1, 1'b1,
	{uart_tx, 1'b1}, 2'h0, 2'h0);
// Port 2
assign alt_bus[3*(2*WIDTH+0) +: 3] = gpiom_alt(`GPIOM_F(2, 0), 1'b1, 1'b1, 1'b1,
	2'h0, 2'h0, 2'h0);
assign alt_bus[3*(2*WIDTH+1) +: 3] = gpiom_alt(`GPIOM_F(2, 1), 1'b1, 1'b0, 1'b1,
	2'h0, 2'h0, 2'h0);
assign alt_bus[3*(2*WIDTH+2) +: 3] = gpiom_alt(`GPIOM_F(2, 2), 1'b0, 1'b1, 1'b1,
	2'h0, {clock_out_src, 1'b1}, 2'h0);
assign alt_bus[3*(2*WIDTH+3) +: 3] = 3'h0;
assign alt_bus[3*(2*WIDTH+4) +: 3] = gpiom_alt(`GPIOM_F(2, 4), 1'b1, 1'b1, 1'b1,
	2'h0, {pwm_out[6], 1'b1}, {logic_array_output[18], 1'b1});
assign alt_bus[3*(2*WIDTH+5) +: 3] = gpiom_alt(`GPIOM_F(2, 5), 1'b0, 1'b1, 1'b1,
	2'h0, {pwm_out[7], 1'b1}, {logic_array_output[19], 1'b1});
assign alt_bus[3*(2*WIDTH+6) +: 3] = gpiom_alt(`GPIOM_F(2, 6), 1'b0, 1'b0, 1'b1,
	2'h0, 2'h0, {logic_array_output[20], 1'b1});
assign alt_bus[3*(2*WIDTH+7) +: 3] = gpiom_alt(`GPIOM_F(2, 7), 1'b0, 1'b0, 1'b1,
	2'h0, 2'h0, {logic_array_output[21], 1'b1});

// Unpack routing entries per pin
generate
	for (k = 0; k < 4*WIDTH; k = k + 1) begin : g_unpack
		assign alt_sel[k] = alt_bus[3*k+2];
		assign alt_out[k] = alt_bus[3*k+1];
		assign alt_oe[k] = alt_bus[3*k];
	end
endgenerate

// ============================================================
// Pin inputs to peripherals: two flops, then gated by selected code
always @(posedge sys_clk or posedge rst) begin
	if (rst) begin
		psync1_q <= {4*WIDTH{1'b0}};
		psync2_q <= {4*WIDTH{1'b0}};
	end else begin
		psync1_q <= pad_in;
		psync2_q <= psync1_q;
	end
end

// Peripheral input registers; low while the pin is not routed
always @(posedge sys_clk or posedge rst) begin
	if (rst) begin
		spi_first_in <= 4'h0;
		i2c_in <= 4'h0;
		uart_rx <= 1'b0;
		external_clock_input <= 1'b0;
		logic_array_clock_a <= 1'b0;
		logic_array_clock_b <= 1'b0;
		logic_array_clock_c <= 1'b0;
		spi_second_in <= 4'h0;
		pwm_trip_input <= 1'b0;
		pwm_sync_input <= 1'b0;
		adc_convert_start <= 1'b0;
		logic_array_input <= 16'h0000;
	end else begin
		spi_first_in <= {(`GPIOM_F(0, 3) == `GPIOM_FS_ALT1) & psync2_q[3],
			(`GPIOM_F(0, 2) == `GPIOM_FS_ALT1) & psync2_q[2],
			(`GPIOM_F(0, 1) == `GPIOM_FS_ALT1) & psync2_q[1],
			(`GPIOM_F(0, 0) == `GPIOM_FS_ALT1) & psync2_q[0]};
		i2c_in <= {(`GPIOM_F(0, 7) == `GPIOM_FS_ALT1) & psync2_q[7],
			(`GPIOM_F(0, 6) == `GPIOM_FS_ALT1) & psync2_q[6],
			(`GPIOM_F(0, 5) == `GPIOM_FS_ALT1) & psync2_q[5],
			(`GPIOM_F(0, 4) == `GPIOM_FS_ALT1) & psync2_q[4]};
		logic_array_clock_a <= (`GPIOM_F(0, 3) == `GPIOM_FS_ALT2) & psync2_q[3];
		uart_rx <= (`GPIOM_F(1, 0) == `GPIOM_FS_ALT1) & psync2_q[WIDTH];
		external_clock_input <= (`GPIOM_F(1, 0) == `GPIOM_FS_ALT2) & psync2_q[WIDTH];
		logic_array_clock_b <= (`GPIOM_F(1, 1) == `GPIOM_FS_ALT2) & psync2_q[WIDTH+1];
		spi_second_in <= {(`GPIOM_F(1, 7) == `GPIOM_FS_ALT2) & psync2_q[WIDTH+7],
			(`GPIOM_F(1, 6) == `GPIOM_FS_ALT2) & psync2_q[WIDTH+6],
			(`GPIOM_F(1, 5) == `GPIOM_FS_ALT2) & psync2_q[WIDTH+5],
			(`GPIOM_F(1, 4) == `GPIOM_FS_ALT2) & psync2_q[WIDTH+4]};
		pwm_trip_input <= (`GPIOM_F(2, 0) == `GPIOM_FS_ALT1) & psync2_q[2*WIDTH];
		logic_array_clock_c <= (`GPIOM_F(2, 0) == `GPIOM_FS_ALT2) & psync2_q[2*WIDTH];
		pwm_sync_input <= (`GPIOM_F(2, 1) == `GPIOM_FS_ALT1) & psync2_q[2*WIDTH+1];
		adc_convert_start <= (`GPIOM_F(2, 4) == `GPIOM_FS_ALT1) & psync2_q[2*WIDTH+4];
		logic_array_input <= {
			(`GPIOM_F(3, 3) == `GPIOM_FS_ALT3) & psync2_q[3*WIDTH+3],
			(`GPIOM_F(3, 2) == `GPIOM_FS_ALT3) & psync2_q[3*WIDTH+2],
			(`GPIOM_F(3, 1) == `GPIOM_FS_ALT3) & psync2_q[3*WIDTH+1],
			(`GPIOM_F(3, 0) == `GPIOM_FS_ALT3) & psync2_q[3*WIDTH],
			1'b0,
			(`GPIOM_F(2, 2) == `GPIOM_FS_ALT3) & psync2_q[2*WIDTH+2],
			(`GPIOM_F(2, 1) == `GPIOM_FS_ALT3) & psync2_q[2*WIDTH+1],
			(`GPIOM_F(2, 0) == `GPIOM_FS_ALT3) & psync2_q[2*WIDTH],
			(`GPIOM_F(1, 3) == `GPIOM_FS_ALT3) & psync2_q[WIDTH+3],
			(`GPIOM_F(1, 2) == `GPIOM_FS_ALT3) & psync2_q[WIDTH+2],
			(`GPIOM_F(1, 1) == `GPIOM_FS_ALT3) & psync2_q[WIDTH+1],
			(`GPIOM_F(1, 0) == `GPIOM_FS_ALT3) & psync2_q[WIDTH],
			(`GPIOM_F(0, 3) == `GPIOM_FS_ALT3) & psync2_q[3],
			(`GPIOM_F(0, 2) == `GPIOM_FS_ALT3) & psync2_q[2],
			(`GPIOM_F(0, 1) == `GPIOM_FS_ALT3) & psync2_q[1],
			(`GPIOM_F(0, 0) == `GPIOM_FS_ALT3) & psync2_q[0]};
	end
end

`undef GPIOM_F

endmodule // gpiom_top
